// ---- rtl/tsc_pkg.sv ----
package tsc_pkg;
  // register byte offsets
  localparam logic [7:0] TSC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] TSC_OFF_SWLEN    = 8'h04;
  localparam logic [7:0] TSC_OFF_PRE      = 8'h08;
  localparam logic [7:0] TSC_OFF_DELAY    = 8'h0C;
  localparam logic [7:0] TSC_OFF_NSWEEP   = 8'h10;
  localparam logic [7:0] TSC_OFF_STATUS   = 8'h14;
  localparam logic [7:0] TSC_OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] TSC_OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] TSC_OFF_COUNT    = 8'h20;
  // control fields
  localparam int TSC_CTRL_RUN     = 0;
  localparam int TSC_CTRL_MODE_LO = 1;
  localparam int TSC_CTRL_MODE_HI = 3;
  localparam int TSC_CTRL_STRETCH = 4;
  localparam int TSC_CTRL_DLYEN   = 5;
  localparam int TSC_CTRL_FAST    = 6;
  localparam int TSC_CTRL_CTRIG   = 7;
  // interrupt bits
  localparam int TSC_IRQ_DONE    = 0;
  localparam int TSC_IRQ_OVERRUN = 1;
  localparam int TSC_IRQ_STRETCH = 2;
  localparam int TSC_IRQ_LIMIT   = 3;
  localparam int TSC_IRQ_W       = 4;
  // reset values
  localparam logic [31:0] TSC_RST_SWLEN  = 32'h0000_0400;
  localparam logic [31:0] TSC_RST_PRE    = 32'h0000_0000;
  localparam logic [31:0] TSC_RST_NSWEEP = 32'h0000_0001;
  // timing
  localparam int TSC_CLK_MHZ      = 200;
  localparam int TSC_RATE_US      = 2500;
  localparam int TSC_RATE_CYC     = TSC_RATE_US * TSC_CLK_MHZ;
  localparam int TSC_DELAY_MAX_S  = 1000;
  localparam int TSC_DELAY_MAX_MS = TSC_DELAY_MAX_S * 1000;
  localparam int TSC_MAX_SWEEPS   = 200000;
  // modes and sweep states
  typedef enum logic [2:0] {
    TSC_M_SINGLE   = 3'h0,
    TSC_M_MULTI    = 3'h1,
    TSC_M_SLOWFAST = 3'h2,
    TSC_M_CONT     = 3'h3,
    TSC_M_DUAL     = 3'h4
  } tsc_mode_t;
  typedef enum logic [2:0] {
    TSC_S_IDLE  = 3'h0,
    TSC_S_PRE   = 3'h1,
    TSC_S_DELAY = 3'h2,
    TSC_S_POST  = 3'h3,
    TSC_S_WAIT  = 3'h4
  } tsc_state_t;
endpackage

// ---- rtl/tsc_capture.sv ----
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module tsc_capture
  import tsc_pkg::*;
#(
  parameter int AW         = 16,
  parameter int DW         = 16,
  parameter int RATE_CYC   = TSC_RATE_CYC,
  parameter int MS_CYC     = TSC_CLK_MHZ * 1000,
  parameter int MAX_SWEEPS = TSC_MAX_SWEEPS
) (
  // clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  // apb slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // sample input
  input  wire logic          smp_valid_i,
  input  wire logic [DW-1:0] smp_data_i,
  input  wire logic          trig_i,
  // memory write port
  output logic               mem_we_o,
  output logic [AW-1:0]      mem_addr_o,
  output logic [DW-1:0]      mem_data_o,
  // storage hand-off
  output logic               st_start_o,
  output logic [AW-1:0]      st_base_o,
  output logic [AW-1:0]      st_len_o,
  output logic               st_marker_o,
  input  wire logic          st_done_i,
  // continuous stream
  output logic               cs_valid_o,
  output logic [DW-1:0]      cs_data_o,
  // rate control and interrupt
  output logic               fast_rate_o,
  output logic               irq_o
);
  localparam logic [AW:0] MEM_SIZE = {1'b1, {AW{1'b0}}};
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]          ctrl_r;
  logic [AW-1:0]       swlen_r;
  logic [AW-1:0]       pre_r;
  logic [31:0]         delay_r;
  logic [17:0]         nsweep_r;
  logic [TSC_IRQ_W-1:0] ist_r;
  logic [TSC_IRQ_W-1:0] imask_r;
  tsc_state_t          st_r;
  logic [AW-1:0]       wp_r;
  logic [AW-1:0]       sw_base_r;
  logic [AW-1:0]       pre_cnt_r;
  logic [AW-1:0]       post_cnt_r;
  logic [AW-1:0]       sweep_used_r;
  logic [31:0]         dly_cnt_r;
  logic [19:0]         dly_ms_r;
  logic [31:0]         rate_cnt_r;
  logic [31:0]         str_cnt_r;
  logic [17:0]         done_cnt_r;
  logic [AW:0]         used_r;
  logic [AW-1:0]       rd_base_r;
  logic [AW-1:0]       q_len_r [4];
  logic [1:0]          q_wp_r;
  logic [1:0]          q_rp_r;
  logic [2:0]          q_cnt_r;
  logic                st_busy_r;
  logic [TSC_IRQ_W-1:0] ev;
  ////////////////////////////////////////////////////////////////////////
  // decode
  tsc_mode_t mode;
  wire run       = ctrl_r[TSC_CTRL_RUN];
  wire str_en    = ctrl_r[TSC_CTRL_STRETCH];
  wire dly_en    = ctrl_r[TSC_CTRL_DLYEN];
  assign mode    = tsc_mode_t'(ctrl_r[TSC_CTRL_MODE_HI:TSC_CTRL_MODE_LO]);
  wire sweeping  = (mode != TSC_M_CONT);
  wire streaming = (mode == TSC_M_CONT) || (mode == TSC_M_DUAL);
  wire multi     = (mode == TSC_M_MULTI) || (mode == TSC_M_DUAL);
  wire apb_wr    = psel_i && penable_i && pwrite_i;
  wire apb_rd    = psel_i && penable_i && !pwrite_i;
  wire smp       = run && smp_valid_i;
  wire rate_ok   = (rate_cnt_r == 32'h0);
  wire str_ok    = (str_cnt_r == 32'h0);
  wire [AW:0] free_words = MEM_SIZE - used_r;
  wire full_fits = (free_words >= {1'b0, swlen_r});
  wire [AW-1:0] post_len   = dly_en ? swlen_r : swlen_r - pre_r;
  wire [AW-1:0] sw_len_now = dly_en ? swlen_r : pre_cnt_r + post_len;
  // stretch room is free words plus one sweep; the extra is not reserved
  wire [AW+1:0] str_need = {2'b0, sweep_used_r} + {2'b0, post_len};
  wire [AW+1:0] str_room = {1'b0, free_words} + {2'b0, swlen_r};
  wire str_fits  = (str_need <= str_room);
  wire limit_hit = multi && (done_cnt_r >= 18'(MAX_SWEEPS));
  wire cap_trig  = trig_i && run && sweeping && rate_ok && !limit_hit;
  wire pre_full  = (pre_cnt_r >= pre_r);
  wire post_last = ({1'b0, post_cnt_r} + 1'b1 >= {1'b0, post_len});
  wire drop_trig = trig_i && run && !full_fits && (st_r[2:1] == 2'b00);
  wire pre_wr    = (st_r == TSC_S_PRE) && (pre_r != '0);
  wire q_pop     = st_done_i && st_busy_r;
  ////////////////////////////////////////////////////////////////////////
  // sweep state machine
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r         <= TSC_S_IDLE;
      wp_r         <= '0;
      sw_base_r    <= '0;
      pre_cnt_r    <= '0;
      post_cnt_r   <= '0;
      sweep_used_r <= '0;
      dly_cnt_r    <= '0;
      dly_ms_r     <= '0;
      rate_cnt_r   <= '0;
      str_cnt_r    <= '0;
      done_cnt_r   <= '0;
      ev           <= '0;
    end else begin
      ev <= '0;
      if (trig_i && run && limit_hit)
        ev[TSC_IRQ_LIMIT] <= 1'b1;
      if (drop_trig)
        ev[TSC_IRQ_OVERRUN] <= 1'b1;
      if (rate_cnt_r != 32'h0)
        rate_cnt_r <= rate_cnt_r - 32'h1;
      if (str_cnt_r != 32'h0)
        str_cnt_r <= str_cnt_r - 32'h1;
      if (smp && st_r != TSC_S_IDLE && st_r != TSC_S_WAIT && st_r != TSC_S_DELAY)
        wp_r <= wp_r + 1'b1;
      case (st_r)
        TSC_S_IDLE: begin
          if (run && sweeping && !limit_hit && full_fits) begin
            st_r      <= TSC_S_PRE;
            sw_base_r <= wp_r;
            pre_cnt_r <= '0;
          end
        end
        TSC_S_PRE: begin
          if (cap_trig && full_fits) begin
            rate_cnt_r <= 32'(RATE_CYC - 1);
            post_cnt_r <= '0;
            sweep_used_r <= pre_cnt_r;
            if (dly_en) begin
              st_r      <= TSC_S_DELAY;
              dly_cnt_r <= '0;
              dly_ms_r  <= '0;
            end else
              st_r <= TSC_S_POST;
          end else if (smp && !pre_full) begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
          end else if (smp) begin
            sw_base_r <= sw_base_r + 1'b1;
          end
        end
        TSC_S_DELAY: begin
          // delay counted in ms ticks; whole sweep becomes post data
          if (dly_cnt_r == 32'(MS_CYC - 1)) begin
            dly_cnt_r <= '0;
            dly_ms_r  <= dly_ms_r + 1'b1;
          end else
            dly_cnt_r <= dly_cnt_r + 32'h1;
          if (dly_ms_r >= delay_r[19:0]) begin
            st_r      <= TSC_S_POST;
            pre_cnt_r <= '0;
            sw_base_r <= wp_r;
          end
        end
        TSC_S_POST: begin
          if (trig_i && str_en && str_ok && str_fits) begin
            post_cnt_r <= '0;
            str_cnt_r  <= 32'(RATE_CYC - 1);
            ev[TSC_IRQ_STRETCH] <= 1'b1;
          end else if (smp) begin
            post_cnt_r   <= post_cnt_r + 1'b1;
            sweep_used_r <= sweep_used_r + 1'b1;
            if (post_last) begin
              ev[TSC_IRQ_DONE] <= 1'b1;
              done_cnt_r <= done_cnt_r + 1'b1;
              // zero re-arm: next sweep opens at once in multi mode
              st_r      <= multi ? TSC_S_IDLE : TSC_S_WAIT;
            end
          end
        end
        default: begin
          if (!run)
            st_r <= TSC_S_IDLE;
        end
      endcase
      if (!run && st_r != TSC_S_IDLE)
        st_r <= TSC_S_IDLE;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // storage hand-off, one sweep at a time in capture order
  wire trig_seen = (st_r == TSC_S_PRE) && cap_trig && full_fits && !dly_en;
  wire dly_done  = (st_r == TSC_S_DELAY) && (dly_ms_r >= delay_r[19:0]);
  wire hand_new  = trig_seen || dly_done;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      used_r      <= '0;
      rd_base_r   <= '0;
      q_wp_r      <= '0;
      q_rp_r      <= '0;
      q_cnt_r     <= '0;
      st_busy_r   <= 1'b0;
      st_start_o  <= 1'b0;
      st_base_o   <= '0;
      st_len_o    <= '0;
      st_marker_o <= 1'b0;
      for (int i = 0; i < 4; i++)
        q_len_r[i] <= '0;
    end else begin
      st_start_o  <= 1'b0;
      st_marker_o <= 1'b0;
      if (drop_trig)
        st_marker_o <= 1'b1;
      if (hand_new && !q_pop)
        used_r <= used_r + {1'b0, sw_len_now};
      else if (q_pop && !hand_new)
        used_r <= used_r - {1'b0, q_len_r[q_rp_r]};
      else if (q_pop && hand_new)
        used_r <= used_r + {1'b0, sw_len_now} - {1'b0, q_len_r[q_rp_r]};
      if (hand_new) begin
        q_len_r[q_wp_r] <= sw_len_now;
        q_wp_r <= q_wp_r + 1'b1;
      end
      // start the hand-off at trigger time, or at delay end when the delay is on, not at sweep end
      if (!st_busy_r && (q_cnt_r != 3'h0 || hand_new)) begin
        st_busy_r  <= 1'b1;
        st_start_o <= 1'b1;
        st_base_o  <= rd_base_r;
        st_len_o   <= q_cnt_r != 3'h0 ? q_len_r[q_rp_r] : sw_len_now;
      end else if (q_pop) begin
        st_busy_r <= 1'b0;
        rd_base_r <= rd_base_r + q_len_r[q_rp_r];
        q_rp_r    <= q_rp_r + 1'b1;
      end
      q_cnt_r <= q_cnt_r + {2'b0, hand_new} - {2'b0, q_pop};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // sample paths
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_data_o  <= '0;
      cs_valid_o  <= 1'b0;
      cs_data_o   <= '0;
      fast_rate_o <= 1'b0;
    end else begin
      mem_we_o   <= smp && (pre_wr || st_r == TSC_S_POST);
      mem_addr_o <= wp_r;
      mem_data_o <= smp_data_i;
      // untriggered stream runs freely; triggered waits for a trigger
      cs_valid_o <= smp && streaming
                    && (!ctrl_r[TSC_CTRL_CTRIG] || trig_i || cs_valid_o);
      cs_data_o  <= smp_data_i;
      fast_rate_o <= (mode == TSC_M_SLOWFAST) && ctrl_r[TSC_CTRL_FAST]
                     && (st_r == TSC_S_POST);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // apb registers
  wire [TSC_IRQ_W-1:0] w1c = (apb_wr && paddr_i == TSC_OFF_IRQ_STAT)
                             ? pwdata_i[TSC_IRQ_W-1:0] : '0;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r   <= '0;
      swlen_r  <= AW'(TSC_RST_SWLEN);
      pre_r    <= AW'(TSC_RST_PRE);
      delay_r  <= '0;
      nsweep_r <= 18'(TSC_RST_NSWEEP);
      ist_r    <= '0;
      imask_r  <= '0;
    end else begin
      if (apb_wr && paddr_i == TSC_OFF_CTRL)
        ctrl_r <= pwdata_i[7:0];
      if (apb_wr && paddr_i == TSC_OFF_SWLEN)
        swlen_r <= pwdata_i[AW-1:0];
      // pre share clipped to the sweep length
      if (apb_wr && paddr_i == TSC_OFF_PRE)
        pre_r <= (pwdata_i[AW-1:0] > swlen_r) ? swlen_r
                 : pwdata_i[AW-1:0];
      if (apb_wr && paddr_i == TSC_OFF_DELAY)
        delay_r <= (pwdata_i > 32'(TSC_DELAY_MAX_MS)) ? 32'(TSC_DELAY_MAX_MS)
                   : pwdata_i;
      if (apb_wr && paddr_i == TSC_OFF_NSWEEP)
        nsweep_r <= pwdata_i[17:0];
      if (apb_wr && paddr_i == TSC_OFF_IRQ_MASK)
        imask_r <= pwdata_i[TSC_IRQ_W-1:0];
      // set wins over clear
      ist_r <= (ist_r & ~w1c) | ev;
    end
  end
  wire known = (paddr_i <= TSC_OFF_COUNT) && (paddr_i[1:0] == 2'b00);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !known;
  always_comb begin
    prdata_o = 32'h0;
    if (apb_rd) begin
      if (paddr_i == TSC_OFF_CTRL)
        prdata_o = {24'h0, ctrl_r};
      else if (paddr_i == TSC_OFF_SWLEN)
        prdata_o = 32'(swlen_r);
      else if (paddr_i == TSC_OFF_PRE)
        prdata_o = 32'(pre_r);
      else if (paddr_i == TSC_OFF_DELAY)
        prdata_o = delay_r;
      else if (paddr_i == TSC_OFF_NSWEEP)
        prdata_o = 32'(nsweep_r);
      else if (paddr_i == TSC_OFF_STATUS)
        prdata_o = {20'h0, q_cnt_r, st_busy_r, 5'h0, st_r};
      else if (paddr_i == TSC_OFF_IRQ_STAT)
        prdata_o = 32'(ist_r);
      else if (paddr_i == TSC_OFF_IRQ_MASK)
        prdata_o = 32'(imask_r);
      else if (paddr_i == TSC_OFF_COUNT)
        prdata_o = 32'(done_cnt_r);
    end
  end
  assign irq_o = |(ist_r & imask_r);
  ////////////////////////////////////////////////////////////////////////
  // checks
  stretch_gap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ev[TSC_IRQ_STRETCH] |-> ##1 !ev[TSC_IRQ_STRETCH])
    else $error("stretch twice in one interval");
  start_gap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r == TSC_S_PRE && cap_trig && full_fits) |=> rate_cnt_r != 32'h0)
    else $error("sweep rate limit not armed");
  nostr_post_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r == TSC_S_POST && !str_en && !smp) |=> $stable(post_cnt_r))
    else $error("post count moved without stretch");
  limit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r == TSC_S_IDLE && limit_hit) |=> st_r != TSC_S_PRE)
    else $error("sweep taken beyond limit");
  marker_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st_marker_o |-> $past(!full_fits))
    else $error("marker with free memory");
  handoff_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (trig_seen && !st_busy_r && q_cnt_r == 3'h0) |=> st_start_o)
    else $error("hand-off not started at trigger");
  fast_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fast_rate_o |-> $past(st_r) == TSC_S_POST)
    else $error("fast rate outside post part");
  order_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st_start_o |-> ##1 !st_start_o)
    else $error("two hand-offs at once");
  sweep_c: cover property (@(posedge sys_clk_i) ev[TSC_IRQ_DONE]);
  stretch_c: cover property (@(posedge sys_clk_i) ev[TSC_IRQ_STRETCH]);
  overrun_c: cover property (@(posedge sys_clk_i) st_marker_o);
endmodule

// ---- test/tsc_host_model.sv ----
`timescale 1ns/1ps
module tsc_host_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // storage hand-off
  input  wire logic        st_start_i,
  input  wire logic        st_marker_i,
  input  wire logic [15:0] lat_i,
  output logic             st_done_o,
  // bookkeeping for the bench
  output logic [7:0]       n_start_o,
  output logic [7:0]       n_marker_o,
  output logic             clash_o
);
  logic [15:0] cnt_r;
  logic        busy_r;
  //////////////////////////////////////////////////////////////////////////
  // one sweep in flight; lat_i must cover the capture, a real host cannot
  // finish storing samples that do not exist yet
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_r      <= 16'h0;
      busy_r     <= 1'b0;
      st_done_o  <= 1'b0;
      n_start_o  <= 8'h0;
      n_marker_o <= 8'h0;
      clash_o    <= 1'b0;
    end else begin
      st_done_o <= 1'b0;
      if (st_marker_i) begin
        n_marker_o <= n_marker_o + 8'h1;
      end
      if (st_start_i) begin
        n_start_o <= n_start_o + 8'h1;
        busy_r    <= 1'b1;
        cnt_r     <= lat_i;
        clash_o   <= clash_o | busy_r;
      end else if (busy_r && cnt_r == 16'h0) begin
        busy_r    <= 1'b0;
        st_done_o <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 16'h1;
      end
    end
  end
endmodule

// ---- test/triggered_sweep_capture_tb.sv ----
`timescale 1ns/1ps
module triggered_sweep_capture_tb;
  import tsc_pkg::*;
  localparam logic [31:0] F_STR = 32'h1 << TSC_CTRL_STRETCH;
  localparam logic [31:0] F_DLY = 32'h1 << TSC_CTRL_DLYEN;
  localparam logic [31:0] F_FST = 32'h1 << TSC_CTRL_FAST;
  // the bench instance keeps 5 address bits of sweep length
  localparam logic [31:0] AWM   = 32'h0000_001F;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, n_start, n_marker;
  logic [31:0] pwdata, prdata, rd;
  logic        smp_valid, trig, smp_on, mem_we, st_start, st_marker;
  logic        st_done, cs_valid, fast_rate, irq, clash, rerr;
  logic [15:0] smp_data, mem_data, cs_data, host_lat;
  logic [4:0]  mem_addr, st_base, st_len, last_len;
  int          n_we, n_cs, err_total, n_checks;

  tsc_capture #(.AW(5), .DW(16), .RATE_CYC(50), .MS_CYC(10),
    .MAX_SWEEPS(3)) DUT (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .smp_valid_i(smp_valid), .smp_data_i(smp_data),
    .trig_i(trig), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_data_o(mem_data), .st_start_o(st_start), .st_base_o(st_base),
    .st_len_o(st_len), .st_marker_o(st_marker), .st_done_i(st_done),
    .cs_valid_o(cs_valid), .cs_data_o(cs_data),
    .fast_rate_o(fast_rate), .irq_o(irq));
  tsc_host_model HOST (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .st_start_i(st_start),
    .st_marker_i(st_marker), .lat_i(host_lat), .st_done_o(st_done),
    .n_start_o(n_start), .n_marker_o(n_marker), .clash_o(clash));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    smp_data <= smp_data + 16'h1;
    n_we <= rst_n ? n_we + int'(mem_we) : 0;
    n_cs <= rst_n ? n_cs + int'(cs_valid) : 0;
    if (st_start) begin
      last_len <= st_len;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // an idle edge after each transfer keeps psel from being driven twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // samples pause on the trigger cycle so post counts are unambiguous
  task automatic fire();
    trig      <= 1'b1;
    smp_valid <= 1'b0;
    @(posedge sys_clk);
    trig      <= 1'b0;
    smp_valid <= smp_on;
  endtask
  function automatic logic [31:0] mk(input tsc_mode_t m,
                                     input logic [31:0] f);
    return 32'h1 | (32'(m) << TSC_CTRL_MODE_LO) | f;
  endfunction
  task automatic setup(input logic [31:0] len, input logic [31:0] pre,
                       input logic [31:0] dly, input logic [31:0] ctl,
                       input logic [15:0] lat);
    rst_n     <= 1'b0;
    smp_on    = 1'b0;
    smp_valid <= 1'b0;
    host_lat  <= lat;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    apb(1'b1, TSC_OFF_SWLEN, len);
    apb(1'b1, TSC_OFF_PRE, pre);
    apb(1'b1, TSC_OFF_DELAY, dly);
    apb(1'b1, TSC_OFF_CTRL, ctl);
  endtask
  task automatic pre_run(input logic [31:0] pre, input int n,
                         input logic [4:0] exp);
    setup(32'h10, pre, 32'h0, mk(TSC_M_SINGLE, 32'h0), 16'h28);
    smp_valid <= 1'b1;
    cyc(n);
    smp_valid <= 1'b0;
    cyc(2);
    smp_on = 1'b1;
    fire();
    cyc(40);
    chk(32'(last_len), 32'(exp));
  endtask
  task automatic str_run(input logic [31:0] f, input logic [31:0] len,
                         input int g1, input int g2, input int exp);
    setup(len, 32'h0, 32'h0, mk(TSC_M_SINGLE, f), 16'h50);
    smp_on = 1'b1;
    fire();
    cyc(3);
    chk(32'(n_start), 32'h1);
    cyc(g1 - 3);
    fire();
    cyc(g2);
    fire();
    cyc(80);
    chk(32'(n_we), 32'(exp));
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    err_total++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, trig, smp_valid, smp_on, rst_n} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    smp_data = 16'h0;
    host_lat = 16'h28;
    last_len = 5'h0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    rchk(TSC_OFF_SWLEN, TSC_RST_SWLEN & AWM);
    rchk(TSC_OFF_PRE, TSC_RST_PRE);
    rchk(TSC_OFF_NSWEEP, TSC_RST_NSWEEP);
    rchk(8'h24, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, TSC_OFF_PRE, 32'h500);
    rchk(TSC_OFF_PRE, TSC_RST_SWLEN & AWM);
    apb(1'b1, TSC_OFF_DELAY, 32'hFFFF_FFFF);
    rchk(TSC_OFF_DELAY, 32'(TSC_DELAY_MAX_MS));
    pre_run(32'h0, 5, 5'h10);
    pre_run(32'h8, 3, 5'h0B);
    pre_run(32'h10, 20, 5'h10);
    str_run(F_STR, 32'h10, 8, 8, 24);
    apb(1'b0, TSC_OFF_IRQ_STAT, 32'h0);
    chk(32'(rd[TSC_IRQ_STRETCH]), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, TSC_OFF_IRQ_MASK, 32'hF);
    chk(32'(irq), 32'h1);
    apb(1'b1, TSC_OFF_IRQ_STAT, 32'hF);
    chk(32'(irq), 32'h0);
    str_run(32'h0, 32'h10, 8, 8, 16);
    str_run(F_STR, 32'h18, 16, 2, 24);
    // sweep starts spaced below and above the rate window, then the cap
    setup(32'h8, 32'h0, 32'h0, mk(TSC_M_MULTI, 32'h0), 16'h14);
    smp_on = 1'b1;
    fire();
    cyc(20);
    fire();
    cyc(40);
    fire();
    cyc(60);
    fire();
    cyc(60);
    fire();
    cyc(80);
    chk(32'(n_start), 32'h3);
    chk(32'(n_we), 32'h18);
    rchk(TSC_OFF_COUNT, 32'h3);
    chk(32'(clash), 32'h0);
    apb(1'b0, TSC_OFF_IRQ_STAT, 32'h0);
    chk(32'(rd[TSC_IRQ_LIMIT]), 32'h1);
    // slow host: memory holds two sweeps, the third trigger overruns
    setup(32'h10, 32'h0, 32'h0, mk(TSC_M_MULTI, 32'h0), 16'h190);
    smp_on = 1'b1;
    fire();
    cyc(60);
    fire();
    cyc(60);
    fire();
    cyc(5);
    chk(32'(n_marker), 32'h1);
    chk(32'(n_start), 32'h1);
    apb(1'b0, TSC_OFF_IRQ_STAT, 32'h0);
    chk(32'(rd[TSC_IRQ_OVERRUN]), 32'h1);
    cyc(500);
    fire();
    cyc(60);
    chk(32'(n_we), 32'h30);
    cyc(500);
    chk(32'(n_start), 32'h3);
    chk(32'(clash), 32'h0);
    setup(32'h10, 32'h0, 32'h2, mk(TSC_M_SINGLE, F_DLY), 16'h28);
    smp_on = 1'b1;
    fire();
    cyc(3);
    apb(1'b0, TSC_OFF_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'(TSC_S_DELAY));
    chk(32'(n_we), 32'h0);
    cyc(60);
    chk(32'(n_we), 32'h10);
    setup(32'h8, 32'h0, 32'h0, mk(TSC_M_CONT, 32'h0), 16'h28);
    smp_valid <= 1'b1;
    cyc(10);
    smp_valid <= 1'b0;
    cyc(5);
    chk(32'(n_cs), 32'hA);
    setup(32'h8, 32'h0, 32'h0, mk(TSC_M_DUAL, 32'h0), 16'h28);
    smp_on = 1'b1;
    fire();
    cyc(12);
    smp_valid <= 1'b0;
    cyc(20);
    chk(32'(n_we), 32'h8);
    chk(32'(n_cs), 32'hC);
    setup(32'h10, 32'h0, 32'h0, mk(TSC_M_SLOWFAST, F_FST), 16'h28);
    smp_on = 1'b1;
    cyc(3);
    chk(32'(fast_rate), 32'h0);
    fire();
    cyc(4);
    chk(32'(fast_rate), 32'h1);
    cyc(40);
    give_verdict();
  end
endmodule
